/* src/flash_host_pkg.sv */
// Purpose: Shared constants and types for the parallel flash program host.
// Assumes: x16 flash, word addressing, 50 MHz system clock.
// Notes:   Codes without a given value are plain defaults.
package flash_host_pkg;

  // Bus geometry
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int LINE_W = 8;  // 256 words per 512-byte line
  localparam logic [7:0] LINE_LAST = 8'hff;

  // Command addresses and codes
  localparam logic [25:0] UNLOCK1_ADDR = 26'h0000555;
  localparam logic [25:0] UNLOCK2_ADDR = 26'h00002aa;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] BUF_LOAD_CODE = 16'h0025;
  localparam logic [15:0] BUF_CONFIRM_CODE = 16'h0029;
  localparam logic [15:0] PROG_SETUP_CODE = 16'h00a0;  // Plain default
  localparam logic [15:0] STATUS_READ_CODE = 16'h0070; // Plain default
  localparam logic [15:0] CLEAR_STATUS_CODE = 16'h0071; // Plain default

  // Status register fields
  localparam int PROG_FAIL_BIT = 4;
  localparam int BUF_ABORT_BIT = 3;

  // Timing in nanoseconds and derived cycle counts
  localparam int CLK_MHZ = 50;
  localparam int T_WE_LOW_NS = 35;
  localparam int T_WE_HIGH_NS = 20;
  localparam int T_ACCESS_NS = 100;
  localparam int T_BUSY_SETTLE_NS = 100;
  localparam int T_RESET_PULSE_NS = 200;
  localparam int T_RESET_RECOVERY_NS = 35000;
  localparam logic [15:0] WE_LOW_CYC =
    16'((T_WE_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] WE_HIGH_CYC =
    16'((T_WE_HIGH_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] ACCESS_CYC =
    16'((T_ACCESS_NS * CLK_MHZ + 999) / 1000 + 2); // Plus sync delay
  localparam logic [15:0] BUSY_SETTLE_CYC =
    16'((T_BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RESET_PULSE_CYC =
    16'((T_RESET_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [15:0] RESET_RECOVERY_CYC =
    16'((T_RESET_RECOVERY_NS * CLK_MHZ + 999) / 1000);

  // Data FIFO
  localparam int FIFO_DEPTH = 4;

  // Requested operations
  typedef enum logic [1:0] {
    OP_WORD, OP_SHORT_WORD, OP_BUFFER, OP_CLEAR
  } op_t;

endpackage : flash_host_pkg

/* src/host_fifo.sv */
// Purpose: Small valid/ready FIFO in front of the buffer data path.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty are registered; clr empties it at once.
`timescale 1ns/1ps
`default_nettype none
module host_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic room;
    logic empty;
  } fifo_t;

  fifo_t q_r;
  fifo_t q_nxt;

  // Pointer and level update
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    q_nxt = q_r;
    push = in_valid && q_r.room;
    pop = out_ready && !q_r.empty;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = q_r.wp + AW'(1);
    end
    if (pop) begin
      q_nxt.rp = q_r.rp + AW'(1);
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + CW'(1);
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - CW'(1);
    end
    if (clr) begin
      q_nxt.wp = '0;
      q_nxt.rp = '0;
      q_nxt.cnt = '0;
    end
    q_nxt.room = (q_nxt.cnt != CW'(DEPTH)); // Ready leaves as a flop
    q_nxt.empty = (q_nxt.cnt == '0);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, room: 1'b1, empty: 1'b1};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign in_ready = q_r.room;
  assign out_valid = !q_r.empty;
  assign out_data = q_r.mem[q_r.rp];
endmodule : host_fifo
`default_nettype wire

/* src/flash_program_host.sv */
// Purpose: Host controller that programs a parallel NOR flash over its pins.
// Assumes: x16 word mode, one request at a time, data pins synchronised.
// Notes:   Function
`timescale 1ns/1ps
`default_nettype none
module flash_program_host
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // User request
  input wire logic req_valid,
  input wire op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [LINE_W-1:0] req_count,
  input wire logic reset_req,
  // User buffer data stream
  input wire logic wdata_valid,
  output logic wdata_ready,
  input wire logic [DATA_W-1:0] wdata,
  // User result
  output logic busy,
  output logic done,
  output logic refused,
  output logic program_fail_flag,
  output logic buffer_abort_flag,
  output logic interrupted,
  output logic [7:0] status,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic ready_busy_pin
);

  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WE_LOW, S_WE_HIGH, S_BUSY, S_READ, S_RST, S_REC
  } state_t;

  typedef struct packed {
    state_t st;
    op_t op;
    logic [2:0] step;
    logic stat_ph;
    logic last;
    logic [15:0] cnt;
    logic [LINE_W-1:0] left;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] cur;
    logic [DATA_W-1:0] data;
    logic [LINE_W-1:0] wc;
    logic [ADDR_W-1:0] pa;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_n;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic busy;
    logic done;
    logic refused;
    logic fail;
    logic abort;
    logic intr;
    logic [7:0] status;
    logic rb_s1;
    logic rb_s2;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
  } host_t;

  host_t q_r;
  host_t q_nxt;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_clr;
  logic [DATA_W-1:0] fifo_data;

  // Buffer data path with back-pressure to the user stream
  host_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(sys_clk),
    .rst(sys_rst),
    .clr(fifo_clr),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Sequencer: chooses each bus write, times strobes, polls, reads status
  always_comb begin
    logic go;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic fin;
    logic [LINE_W:0] end_off;
    go = 1'b0;
    wa = '0;
    wd = '0;
    fin = 1'b0;
    end_off = '0;
    q_nxt = q_r;
    fifo_pop = 1'b0;
    fifo_clr = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.refused = 1'b0;
    // Pin inputs pass two flip-flops before use
    q_nxt.rb_s1 = ready_busy_pin;
    q_nxt.rb_s2 = q_r.rb_s1;
    q_nxt.dq_s1 = flash_dq_in;
    q_nxt.dq_s2 = q_r.dq_s1;
    unique case (q_r.st)
      S_IDLE: begin
        end_off = {1'b0, req_addr[LINE_W-1:0]} + {1'b0, req_count};
        if (req_valid) begin
          if (req_op == OP_BUFFER && end_off[LINE_W]) begin
            q_nxt.refused = 1'b1;
          end else begin
            q_nxt.op = req_op;
            q_nxt.addr = req_addr;
            q_nxt.cur = req_addr;
            q_nxt.data = req_data;
            q_nxt.wc = req_count; // 1 to 256 words
            q_nxt.left = req_count;
            q_nxt.step = '0;
            q_nxt.stat_ph = 1'b0;
            q_nxt.intr = 1'b0;
            q_nxt.busy = 1'b1;
            q_nxt.st = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (q_r.stat_ph) begin
          go = 1'b1; // Status read after completion
          fin = 1'b1;
          wa = UNLOCK1_ADDR;
          wd = STATUS_READ_CODE;
        end else begin
          unique case (q_r.op)
            OP_WORD: begin
              go = 1'b1;
              unique case (q_r.step)
                3'd0: begin wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
                3'd1: begin wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
                3'd2: begin wa = UNLOCK1_ADDR; wd = PROG_SETUP_CODE; end
                default: begin
                  wa = q_r.addr; // Address and data start it
                  wd = q_r.data;
                  fin = 1'b1;
                end
              endcase
            end
            OP_SHORT_WORD: begin
              go = 1'b1; // No unlock writes in overlay spaces
              if (q_r.step == 3'd0) begin
                wa = q_r.addr;
                wd = PROG_SETUP_CODE;
              end else begin
                wa = q_r.addr;
                wd = q_r.data;
                fin = 1'b1;
              end
            end
            OP_BUFFER: begin
              unique case (q_r.step)
                3'd0: begin go = 1'b1; wa = UNLOCK1_ADDR; wd = UNLOCK1_DATA; end
                3'd1: begin go = 1'b1; wa = UNLOCK2_ADDR; wd = UNLOCK2_DATA; end
                3'd2: begin
                  go = 1'b1;
                  wa = q_r.addr;
                  wd = BUF_LOAD_CODE;
                end
                3'd3: begin
                  go = 1'b1;
                  wa = q_r.addr;
                  wd = DATA_W'(q_r.wc); // Words minus one
                end
                3'd4: begin
                  if (fifo_valid) begin
                    go = 1'b1; // Sequential words in one line
                    fifo_pop = 1'b1;
                    wa = q_r.cur;
                    wd = fifo_data;
                  end
                end
                default: begin
                  go = 1'b1; // Confirm right after the last word
                  wa = q_r.addr;
                  wd = BUF_CONFIRM_CODE;
                  fin = 1'b1;
                end
              endcase
            end
            default: begin
              go = 1'b1; // Clears the fail flags in the device
              wa = UNLOCK1_ADDR;
              wd = CLEAR_STATUS_CODE;
              fin = 1'b1;
            end
          endcase
        end
        if (go) begin
          q_nxt.pa = wa;
          q_nxt.dq_o = wd;
          q_nxt.dq_oe_n = 1'b0;
          q_nxt.ce_n = 1'b0;
          q_nxt.we_n = 1'b0;
          q_nxt.last = fin;
          q_nxt.cnt = WE_LOW_CYC - 16'h0001;
          q_nxt.st = S_WE_LOW;
          if (q_r.op == OP_BUFFER && q_r.step == 3'd4 && !q_r.stat_ph) begin
            q_nxt.cur = q_r.cur + 26'h0000001;
            if (q_r.left == '0) begin
              q_nxt.step = 3'd5;
            end else begin
              q_nxt.left = q_r.left - 8'h01; // Mirrors device countdown
            end
          end else begin
            q_nxt.step = q_r.step + 3'd1;
          end
        end
      end
      S_WE_LOW: begin
        if (q_r.cnt == '0) begin
          q_nxt.we_n = 1'b1;
          q_nxt.cnt = WE_HIGH_CYC - 16'h0001;
          q_nxt.st = S_WE_HIGH;
        end else begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end
      S_WE_HIGH: begin
        if (q_r.cnt != '0) begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end else if (!q_r.last) begin
          q_nxt.st = S_ISSUE;
        end else if (q_r.stat_ph) begin
          q_nxt.dq_oe_n = 1'b1;
          q_nxt.oe_n = 1'b0;
          q_nxt.cnt = ACCESS_CYC;
          q_nxt.st = S_READ;
        end else if (q_r.op == OP_CLEAR) begin
          q_nxt.dq_oe_n = 1'b1;
          q_nxt.ce_n = 1'b1;
          q_nxt.fail = 1'b0;
          q_nxt.abort = 1'b0;
          q_nxt.busy = 1'b0;
          q_nxt.done = 1'b1;
          q_nxt.st = S_IDLE;
        end else begin
          q_nxt.dq_oe_n = 1'b1;
          q_nxt.ce_n = 1'b1;
          q_nxt.cnt = BUSY_SETTLE_CYC;
          q_nxt.st = S_BUSY;
        end
      end
      S_BUSY: begin
        // No writes while the device programs
        if (q_r.cnt != '0) begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end else if (q_r.rb_s2) begin
          q_nxt.stat_ph = 1'b1; // Ready pin high
          q_nxt.st = S_ISSUE;
        end
      end
      S_READ: begin
        if (q_r.cnt == '0) begin
          q_nxt.status = q_r.dq_s2[7:0];
          q_nxt.fail = q_r.dq_s2[PROG_FAIL_BIT];
          q_nxt.abort = q_r.dq_s2[BUF_ABORT_BIT];
          q_nxt.oe_n = 1'b1;
          q_nxt.ce_n = 1'b1;
          q_nxt.busy = 1'b0;
          q_nxt.done = 1'b1;
          q_nxt.st = S_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end
      S_RST: begin
        if (q_r.cnt == '0) begin
          q_nxt.rst_n = 1'b1;
          q_nxt.cnt = RESET_RECOVERY_CYC;
          q_nxt.st = S_REC;
        end else begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end
      S_REC: begin
        if (q_r.cnt == '0) begin
          q_nxt.busy = 1'b0; // Device back in read mode
          q_nxt.done = 1'b1;
          q_nxt.st = S_IDLE;
        end else begin
          q_nxt.cnt = q_r.cnt - 16'h0001;
        end
      end
      default: begin
        q_nxt.st = S_IDLE;
      end
    endcase
    // Hardware reset request overrides everything outside the S_RST and S_REC states
    if (reset_req && q_r.st != S_RST && q_r.st != S_REC) begin
      q_nxt.intr = (q_r.st != S_IDLE); // User must redo the area
      q_nxt.rst_n = 1'b0;
      q_nxt.ce_n = 1'b1;
      q_nxt.we_n = 1'b1;
      q_nxt.oe_n = 1'b1;
      q_nxt.dq_oe_n = 1'b1;
      q_nxt.busy = 1'b1;
      q_nxt.done = 1'b0;
      q_nxt.cnt = RESET_PULSE_CYC - 16'h0001;
      q_nxt.st = S_RST;
      fifo_clr = 1'b1;
      fifo_pop = 1'b0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q_r <= '{st: S_IDLE, op: OP_WORD, step: 3'h0, stat_ph: 1'b0,
               last: 1'b0, cnt: 16'h0000, left: 8'h00, addr: '0, cur: '0,
               data: 16'h0000, wc: 8'h00, pa: '0, dq_o: 16'h0000,
               dq_oe_n: 1'b1, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
               rst_n: 1'b1, busy: 1'b0, done: 1'b0, refused: 1'b0,
               fail: 1'b0, abort: 1'b0, intr: 1'b0, status: 8'h00,
               rb_s1: 1'b0, rb_s2: 1'b0, dq_s1: 16'h0000,
               dq_s2: 16'h0000};
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign busy = q_r.busy;
  assign done = q_r.done;
  assign refused = q_r.refused;
  assign program_fail_flag = q_r.fail;
  assign buffer_abort_flag = q_r.abort;
  assign interrupted = q_r.intr;
  assign status = q_r.status;
  assign flash_addr = q_r.pa;
  assign flash_dq_out = q_r.dq_o;
  assign flash_dq_oe_n = q_r.dq_oe_n;
  assign flash_ce_n = q_r.ce_n;
  assign flash_we_n = q_r.we_n;
  assign flash_oe_n = q_r.oe_n;
  assign flash_reset_n = q_r.rst_n;
endmodule : flash_program_host
`default_nettype wire

/* tb/flash_program_host_asserts.sv */
// Purpose: Concurrent checks on the flash host's pins and user handshake.
// Assumes: One clock domain, reset active high.
// Notes:   Write cycle lengths follow the package's cycle counts.
`timescale 1ns/1ps
`default_nettype none
module flash_program_host_asserts
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // User side
  input wire logic req_valid,
  input wire op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [LINE_W-1:0] req_count,
  input wire logic reset_req,
  input wire logic busy,
  input wire logic refused,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n
);
  logic [7:0] rst_cnt_r;
  logic [8:0] end_w;
  logic [9:0] sec_w;
  logic buf_req;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Helpers: last word of a buffer request, sector bits, reset pin length
  assign end_w = {1'b0, req_addr[7:0]} + {1'b0, req_count};
  assign sec_w = flash_addr[25:16];
  assign buf_req = req_valid && !busy && !reset_req && req_op == OP_BUFFER;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt_r <= 8'h00;
    end else if (!flash_reset_n) begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end else begin
      rst_cnt_r <= 8'h00;
    end
  end

  // Steps of a bus write and of the first unlock
  sequence s_write_cycle;
    (!flash_we_n && !flash_ce_n)[*2] ##1 (flash_we_n && !flash_ce_n);
  endsequence
  sequence s_unlock1;
    $fell(flash_we_n) && flash_addr == UNLOCK1_ADDR &&
      flash_dq_out == UNLOCK1_DATA;
  endsequence

  a_write_shape: assert property (
    $fell(flash_we_n) |-> s_write_cycle) else $error("bad write cycle");
  a_write_drives: assert property (
    !flash_we_n |-> !flash_dq_oe_n && flash_oe_n)
    else $error("data not driven in write");
  a_read_released: assert property (
    !flash_oe_n |-> flash_dq_oe_n && flash_we_n)
    else $error("bus fight in read");
  a_unlock_pair: assert property (
    s_unlock1 |-> ##4 (!flash_we_n && flash_addr == UNLOCK2_ADDR &&
    flash_dq_out == UNLOCK2_DATA)) else $error("second unlock wrong");
  a_load_sector: assert property (
    $fell(flash_we_n) && flash_dq_out == BUF_LOAD_CODE |->
    ##4 (!flash_we_n && sec_w == $past(sec_w, 4)))
    else $error("count not at load sector");
  a_cross_refused: assert property (
    buf_req && end_w > 9'h0ff |=> refused && !busy)
    else $error("line crossing not refused");
  a_fit_taken: assert property (
    buf_req && end_w <= 9'h0ff |=> busy && !refused)
    else $error("fitting buffer not taken");
  a_reset_start: assert property (
    reset_req && flash_reset_n |-> ##[1:3] !flash_reset_n)
    else $error("reset pin not driven");
  a_reset_len: assert property (
    $rose(flash_reset_n) |-> rst_cnt_r == 8'd10)
    else $error("reset pulse length wrong");
  a_reset_quiet: assert property (
    !flash_reset_n |-> flash_we_n && flash_ce_n)
    else $error("write during reset");
endmodule : flash_program_host_asserts
`default_nettype wire

/* tb/flash_dev_model.sv */
// Purpose: Behavioural flash device answering the host's write cycles.
// Assumes: 64K-word sectors, 256-word lines, status after read command.
// Notes:   bad_confirm spoils the confirm so the device aborts.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_NS = 3000
) (
  // Pins from the host
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_reset_n,
  // Pins to the host
  output logic [DATA_W-1:0] flash_dq_in,
  output logic ready_busy_pin,
  // Scenario control and observation
  input wire logic bad_confirm,
  output int words_cnt,
  output logic [ADDR_W-1:0] last_addr
);
  logic [7:0] sr = 8'h00;
  logic [ADDR_W-1:0] sec, nxt;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic prog = 1'b0;
  logic rd_sr = 1'b0;
  int st = 0;
  int left;
  wire [DATA_W-1:0] rd_val = rd_sr ? {8'h00, !prog, sr[6:0]} : 16'hffff;
  wire sec_ok = flash_addr[25:16] == sec[25:16];

  // Busy pin and released data lines toggle away from the last value
  assign ready_busy_pin = !prog;
  assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rd_val : ~last_q;
  always @(posedge flash_oe_n) last_q = rd_val;

  // Embedded program ends, clears fail flags, returns to standby
  always @(posedge prog) begin
    #BUSY_NS;
    if (prog) begin
      prog = 1'b0;
      sr[4:3] = 2'b00;
    end
  end

  task automatic abort_seq();
    sr[4:3] = 2'b11;
    st = 0;
  endtask : abort_seq

  // Command decoder on each completed write cycle
  always @(posedge flash_we_n or negedge flash_reset_n) begin
    if (!flash_reset_n) begin
      st = 0;
      prog = 1'b0;
      rd_sr = 1'b0;
    end else if (!flash_ce_n && !prog) begin
      rd_sr = 1'b0;
      case (st)
        0: begin
          if (flash_dq_out == STATUS_READ_CODE) rd_sr = 1'b1;
          else if (flash_dq_out == CLEAR_STATUS_CODE) sr[4:3] = 2'b00;
          else if (flash_addr == UNLOCK1_ADDR &&
                   flash_dq_out == UNLOCK1_DATA) st = 1;
          else if (flash_dq_out == PROG_SETUP_CODE) st = 3;
        end
        1: st = (flash_addr == UNLOCK2_ADDR &&
                 flash_dq_out == UNLOCK2_DATA) ? 2 : 0;
        2: begin
          sec = flash_addr;
          if (flash_dq_out == PROG_SETUP_CODE) st = 3;
          else if (flash_dq_out == BUF_LOAD_CODE) st = 4;
          else st = 0;
        end
        3: begin
          last_addr = flash_addr;
          words_cnt = 1;
          prog = 1'b1;
          st = 0;
        end
        4: begin
          if (!sec_ok || flash_dq_out > 16'h00ff) abort_seq();
          else begin
            left = flash_dq_out + 1;
            words_cnt = 0; // Buffer starts all ones
            st = 5;
          end
        end
        5: begin
          if (!sec_ok || (words_cnt != 0 && flash_addr != nxt) ||
              (words_cnt != 0 && flash_addr[25:8] != last_addr[25:8]))
            abort_seq();
          else begin
            nxt = flash_addr + 1;
            last_addr = flash_addr;
            words_cnt++;
            left--;
            if (left == 0) st = 6;
          end
        end
        default: begin
          if (flash_dq_out == BUF_CONFIRM_CODE && sec_ok && !bad_confirm) begin
            prog = 1'b1;
            st = 0;
          end else abort_seq();
        end
      endcase
    end
  end
endmodule : flash_dev_model
`default_nettype wire

/* tb/tb_flash_program_host.sv */
// Purpose: Self-checking bench for the flash program host.
// Assumes: Behavioural device model on the flash pins.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb_flash_program_host;
  import flash_host_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  op_t req_op = OP_WORD;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_data = '0;
  logic [LINE_W-1:0] req_count = '0;
  logic reset_req = 1'b0;
  logic wdata_valid = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic bad_confirm = 1'b0;
  logic wdata_ready, busy, done, refused, program_fail_flag;
  logic buffer_abort_flag, interrupted, flash_dq_oe_n, flash_ce_n;
  logic flash_we_n, flash_oe_n, flash_reset_n, ready_busy_pin;
  logic [7:0] status;
  logic [ADDR_W-1:0] flash_addr, last_addr;
  logic [DATA_W-1:0] flash_dq_in, flash_dq_out;
  int words_cnt;
  int error_cnt = 0;
  int samples_checked = 0;

  flash_program_host flash_program_host_inst (.sys_clk, .sys_rst,
    .req_valid, .req_op, .req_addr, .req_data, .req_count, .reset_req,
    .wdata_valid, .wdata_ready, .wdata, .busy, .done, .refused,
    .program_fail_flag, .buffer_abort_flag, .interrupted, .status,
    .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe_n, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_reset_n, .ready_busy_pin);
  flash_dev_model flash_dev_model_inst (.flash_addr, .flash_dq_out,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .flash_dq_in,
    .ready_busy_pin, .bad_confirm, .words_cnt, .last_addr);

  // Clock
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wait_for(ref logic sig, input int lim);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < lim) begin
      tick();
      n++;
    end
    if (sig !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED wait exp 1 got %b", sig);
      summarize();
    end
  endtask : wait_for

  task automatic issue(input op_t op, input logic [25:0] a,
                       input logic [15:0] d, input logic [7:0] c);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_count = c;
    tick();
    req_valid = 1'b0;
  endtask : issue

  task automatic push_word(input logic [15:0] v);
    wdata_valid = 1'b1;
    wdata = v;
    wait_for(wdata_ready, 400);
    tick();
  endtask : push_word

  task automatic t_word();
    issue(OP_WORD, 26'h0012340, 16'h1234, 8'h00);
    `CHK("busy", 1'b1, busy)
    wait_for(done, 600);
    `CHK("word addr", 26'h0012340, last_addr)
    `CHK("word status", 8'h80, status)
    `CHK("word fail", 1'b0, program_fail_flag)
    issue(OP_SHORT_WORD, 26'h0012350, 16'h00ff, 8'h00);
    wait_for(done, 600);
    `CHK("short addr", 26'h0012350, last_addr)
    `CHK("short status", 8'h80, status)
    $display("word test ended");
  endtask : t_word

  task automatic t_buffer();
    int n;
    n = 0;
    wdata_valid = 1'b1;
    while (wdata_ready === 1'b1 && n < 8) begin
      wdata = 16'h0100 + 16'(n);
      tick();
      n++;
    end
    wdata_valid = 1'b0;
    `CHK("fifo fill", FIFO_DEPTH, n)
    issue(OP_BUFFER, 26'h0010200, 16'h0000, 8'h05);
    push_word(16'h0104);
    push_word(16'h0105);
    wdata_valid = 1'b0;
    wait_for(done, 800);
    `CHK("buf words", 6, words_cnt)
    `CHK("buf last", 26'h0010205, last_addr)
    `CHK("buf status", 8'h80, status)
    `CHK("buf abort", 1'b0, buffer_abort_flag)
    $display("buffer test ended");
  endtask : t_buffer

  task automatic t_cross();
    issue(OP_BUFFER, 26'h00100f0, 16'h0000, 8'h20);
    `CHK("refused", 1'b1, refused)
    `CHK("cross busy", 1'b0, busy)
    $display("crossing test ended");
  endtask : t_cross

  task automatic t_abort();
    bad_confirm = 1'b1;
    push_word(16'h0bad);
    wdata_valid = 1'b0;
    issue(OP_BUFFER, 26'h0020000, 16'h0000, 8'h00);
    wait_for(done, 600);
    bad_confirm = 1'b0;
    `CHK("fail flag", 1'b1, program_fail_flag)
    `CHK("abort flag", 1'b1, buffer_abort_flag)
    `CHK("abort status", 8'h98, status)
    issue(OP_CLEAR, 26'h0000000, 16'h0000, 8'h00);
    wait_for(done, 200);
    `CHK("cleared fail", 1'b0, program_fail_flag)
    `CHK("cleared abort", 1'b0, buffer_abort_flag)
    $display("abort test ended");
  endtask : t_abort

  task automatic t_reset();
    int n;
    issue(OP_WORD, 26'h0030000, 16'h5a5a, 8'h00);
    n = 0;
    // Bounded wait for the device to start its embedded program
    while (ready_busy_pin !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    if (ready_busy_pin !== 1'b0) begin
      error_cnt++;
      $display("CHECK FAILED ready_busy_pin exp 0 got %b", ready_busy_pin);
      summarize();
    end
    reset_req = 1'b1;
    tick();
    reset_req = 1'b0;
    wait_for(done, 2500);
    `CHK("interrupted", 1'b1, interrupted)
    `CHK("dev ready", 1'b1, ready_busy_pin)
    issue(OP_WORD, 26'h0030000, 16'h5a5a, 8'h00);
    wait_for(done, 600);
    `CHK("reissue addr", 26'h0030000, last_addr)
    `CHK("reissue flag", 1'b0, interrupted)
    $display("reset test ended");
  endtask : t_reset

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    t_word();
    t_buffer();
    t_cross();
    t_abort();
    t_reset();
    summarize();
  end
endmodule : tb_flash_program_host
bind flash_program_host flash_program_host_asserts
  flash_program_host_asserts_inst (.sys_clk, .sys_rst, .req_valid, .req_op,
  .req_addr, .req_count, .reset_req, .busy, .refused, .flash_addr,
  .flash_dq_out, .flash_dq_oe_n, .flash_ce_n, .flash_we_n, .flash_oe_n,
  .flash_reset_n);
`default_nettype wire
